// ==== common/ast_pkg.sv ====
package ast_pkg;
  // Register port geometry
  localparam int ADDR_W = 3;
  localparam int DATA_W = 8;
  localparam logic [ADDR_W-1:0] ADR_STATUS = 3'h0;
  localparam logic [ADDR_W-1:0] ADR_DATA = 3'h1;
  localparam logic [ADDR_W-1:0] ADR_CONTROL_ONE = 3'h2;
  localparam logic [ADDR_W-1:0] ADR_CONTROL_TWO = 3'h3;
  localparam logic [ADDR_W-1:0] ADR_BAUD = 3'h4;

  // Status register bits
  localparam int ST_TX_BUFFER_EMPTY_FLAG_BIT = 0;
  localparam int ST_TC_BIT = 1;
  localparam int ST_BUSY_BIT = 2;
  // control_one bits
  localparam int C1_T8_BIT = 0;
  localparam int C1_WORD9_BIT = 1;
  // Second control register bits
  localparam int C2_TIE_BIT = 0;
  localparam int C2_TX_COMPLETE_IRQ_EN_BIT = 1;
  localparam int C2_TE_BIT = 2;
  localparam int C2_SBK_BIT = 3;

  // Reset values
  localparam logic [DATA_W-1:0] BAUD_RST = 8'h0f;
  localparam logic TX_BUFFER_EMPTY_FLAG_RST = 1'b1;
  localparam logic TC_RST = 1'b1;

  // Frame geometry in bit times
  localparam int FRAME_W = 11;
  localparam logic [3:0] FRAME_LEN8 = 4'ha;
  localparam logic [3:0] FRAME_LEN9 = 4'hb;
  localparam logic [3:0] MARK_LEN = 4'h1;
  localparam logic [FRAME_W-1:0] FRAME_ONES = 11'h7ff;
  localparam logic [FRAME_W-1:0] FRAME_ZEROS = 11'h000;

  // Baud divider: one bit time is (baud+1) * (PRESC_MAX+1) clocks
  localparam logic [3:0] PRESC_MAX = 4'hf;

  typedef enum logic {TX_QUIET, TX_FRAME} ast_state_t;
  typedef enum logic [1:0] {FK_DATA, FK_IDLE, FK_BREAK, FK_MARK} ast_kind_t;
endpackage

// ==== verilog/ast_baud_tick.sv ====
`timescale 1ns/1ns
`default_nettype none
module ast_baud_tick
  import ast_pkg::*;
(
  input wire logic i_clk_sys,
  input wire logic i_rst_b,
  input wire logic i_restart,
  input wire logic [DATA_W-1:0] i_div,
  output logic o_tick
);
  logic [3:0] pre_reg, pre_next;
  logic [DATA_W-1:0] cnt_reg, cnt_next;
  logic tick_reg, tick_next;

  // Restart keeps the first bit of a frame a full bit time long
  always_comb begin
    pre_next = pre_reg;
    cnt_next = cnt_reg;
    tick_next = 1'b0;
    if (i_restart) begin
      pre_next = '0;
      cnt_next = '0;
    end else if (pre_reg == PRESC_MAX) begin
      pre_next = '0;
      if (cnt_reg >= i_div) begin
        cnt_next = '0;
        tick_next = 1'b1;
      end else begin
        cnt_next = cnt_reg + 8'h01;
      end
    end else begin
      pre_next = pre_reg + 4'h1;
    end
  end

  always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
    if (!i_rst_b) begin
      pre_reg <= '0;
      cnt_reg <= '0;
      tick_reg <= 1'b0;
    end else begin
      pre_reg <= pre_next;
      cnt_reg <= cnt_next;
      tick_reg <= tick_next;
    end
  end

  assign o_tick = tick_reg;
endmodule // ast_baud_tick
`default_nettype wire

// ==== verilog/ast_transmitter.sv ====
// Functional notes
// R01: Word length is 8 bits with word-length bit clear, 9 bits when set.
// R02: Serial output is low for the whole start bit.
// R03: Serial output is high for the whole stop bit.
// R04: Idle frame is all ones for a full frame, then next start bit.
// R05: Break is zeros for whole frames, then one extra one bit.
// R06: Transmit has its own baud tick, independent of the receive rate.
// R07: In 9-bit mode the top bit comes from tx_ninth_data_bit.
// R08: Data bits leave least significant bit first.
// R09: Writes during a frame go to the holding buffer, moved at frame end.
// R10: Setting transmitter_on takes the pin and sends one idle frame first.
// R11: Buffer-empty clears only by status access then data-port write.
// R12: Buffer-empty sets when the holding buffer empties and a transfer begins.
// R13: Interrupt while buffer-empty and its enable set, global mask clear.
// R14: A write while idle loads the shifter, starts, and sets buffer-empty.
// R15: Complete flag sets after stop bit or break; interrupt if enabled.
// R16: Complete flag clears by the same status-then-data-write sequence.
// R17: Break frames repeat while send_break_ctl is set, then one closing one.
// R18: Off-then-on mid frame queues an idle frame; holding data is lost.
// R19: Enabled and empty keeps output high; disabled returns the pin to port.
// R20: One bit per baud tick: start, 8 or 9 data bits, one stop bit.
`timescale 1ns/1ns
`default_nettype none
module ast_transmitter
  import ast_pkg::*;
(
  input wire logic i_clk_sys,
  input wire logic i_rst_b,
  input wire logic [ADDR_W-1:0] i_addr,
  input wire logic [DATA_W-1:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  input wire logic i_cpu_irq_mask,
  output logic [DATA_W-1:0] o_rdata,
  output logic o_tx_data,
  output logic o_tx_pin_serial,
  output logic o_irq
);
  ast_state_t state_reg, state_next;
  ast_kind_t kind_reg, kind_next;
  logic [FRAME_W-1:0] shift_reg, shift_next;
  logic [3:0] bit_cnt_reg, bit_cnt_next;
  logic [3:0] frame_len_reg, frame_len_next;
  logic [8:0] hold_reg, hold_next;
  logic hold_valid_reg, hold_valid_next;
  logic tx_buffer_empty_flag_reg, tx_buffer_empty_flag_next;
  logic tc_reg, tc_next;
  logic seen_reg, seen_next;
  logic pend_idle_reg, pend_idle_next;
  logic brk_tail_reg, brk_tail_next;
  logic line_reg, line_next;
  logic pin_reg, pin_next;
  logic irq_reg, irq_next;
  logic [DATA_W-1:0] rdata_reg, rdata_next;
  logic word9_reg, word9_next;
  logic t8_reg, t8_next;
  logic te_reg, te_next;
  logic sbk_reg, sbk_next;
  logic tie_reg, tie_next;
  logic tx_complete_irq_en_reg, tx_complete_irq_en_next;
  logic [DATA_W-1:0] baud_reg, baud_next;
  logic tick, launch, end_evt, wr_data, busy;

  function automatic logic [FRAME_W-1:0] build_frame(input logic w9, input logic [8:0] d);
    // Start bit in bit 0, stop bit above the data, padded with ones
    build_frame = w9 ? {1'b1, d, 1'b0} : {2'b11, d[7:0], 1'b0}; // R02 R03 R07 R08
  endfunction

  function automatic logic [3:0] frame_len(input logic w9);
    frame_len = w9 ? FRAME_LEN9 : FRAME_LEN8; // R01
  endfunction

  // Separate divider keeps transmit rate independent of any receiver
  ast_baud_tick u_tx_tick ( // R06
    .i_clk_sys(i_clk_sys),
    .i_rst_b(i_rst_b),
    .i_restart(launch),
    .i_div(baud_reg),
    .o_tick(tick)
  );

  assign busy = (state_reg == TX_FRAME);
  assign wr_data = i_wr && (i_addr == ADR_DATA);
  assign end_evt = busy && tick && (bit_cnt_reg == frame_len_reg - 4'h1);

  // Control registers
  always_comb begin
    word9_next = word9_reg;
    t8_next = t8_reg;
    te_next = te_reg;
    sbk_next = sbk_reg;
    tie_next = tie_reg;
    tx_complete_irq_en_next = tx_complete_irq_en_reg;
    baud_next = baud_reg;
    if (i_wr && i_addr == ADR_CONTROL_ONE) begin
      word9_next = i_wdata[C1_WORD9_BIT];
      t8_next = i_wdata[C1_T8_BIT];
    end
    if (i_wr && i_addr == ADR_CONTROL_TWO) begin
      te_next = i_wdata[C2_TE_BIT];
      sbk_next = i_wdata[C2_SBK_BIT];
      tie_next = i_wdata[C2_TIE_BIT];
      tx_complete_irq_en_next = i_wdata[C2_TX_COMPLETE_IRQ_EN_BIT];
    end
    if (i_wr && i_addr == ADR_BAUD) begin
      baud_next = i_wdata;
    end
  end

  always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
    if (!i_rst_b) begin
      word9_reg <= 1'b0;
      t8_reg <= 1'b0;
      te_reg <= 1'b0;
      sbk_reg <= 1'b0;
      tie_reg <= 1'b0;
      tx_complete_irq_en_reg <= 1'b0;
      baud_reg <= BAUD_RST;
    end else begin
      word9_reg <= word9_next;
      t8_reg <= t8_next;
      te_reg <= te_next;
      sbk_reg <= sbk_next;
      tie_reg <= tie_next;
      tx_complete_irq_en_reg <= tx_complete_irq_en_next;
      baud_reg <= baud_next;
    end
  end

  // Transmit engine, flags and bus answer
  always_comb begin
    logic can_start;
    logic te_rise, te_fall;
    can_start = te_reg && (!busy || end_evt);
    te_rise = te_next && !te_reg;
    te_fall = !te_next && te_reg;
    state_next = state_reg;
    kind_next = kind_reg;
    shift_next = shift_reg;
    bit_cnt_next = bit_cnt_reg;
    frame_len_next = frame_len_reg;
    hold_next = hold_reg;
    hold_valid_next = hold_valid_reg;
    tx_buffer_empty_flag_next = tx_buffer_empty_flag_reg;
    tc_next = tc_reg;
    seen_next = seen_reg;
    pend_idle_next = pend_idle_reg;
    brk_tail_next = brk_tail_reg;
    line_next = line_reg;
    launch = 1'b0;

    // Clears come first so that a hardware set in the same cycle wins
    if (wr_data && seen_reg) begin
      tx_buffer_empty_flag_next = 1'b0; // R11
      tc_next = 1'b0; // R16
    end

    // Step through the current frame
    if (busy && tick) begin
      if (end_evt) begin
        state_next = TX_QUIET;
        line_next = 1'b1; // R19
        if (kind_reg == FK_DATA || kind_reg == FK_BREAK) begin
          tc_next = 1'b1; // R15
        end
      end else begin
        shift_next = shift_reg >> 1; // R08 R20
        line_next = shift_reg[1];
        bit_cnt_next = bit_cnt_reg + 4'h1; // R20
      end
    end

    if (i_rd && i_addr == ADR_STATUS) begin
      seen_next = 1'b1;
    end else if (wr_data) begin
      seen_next = 1'b0;
    end
    if (wr_data && busy) begin
      hold_next = {t8_reg, i_wdata}; // R09 R07
      hold_valid_next = 1'b1; // R09
    end

    // Pick the next frame, idle first, then break, closing one, data
    if (can_start) begin
      launch = 1'b1;
      bit_cnt_next = '0;
      state_next = TX_FRAME;
      if (pend_idle_reg) begin
        kind_next = FK_IDLE; // R04 R10 R18
        shift_next = FRAME_ONES;
        frame_len_next = frame_len(word9_reg);
        pend_idle_next = 1'b0;
      end else if (sbk_reg) begin
        kind_next = FK_BREAK; // R05 R17
        shift_next = FRAME_ZEROS;
        frame_len_next = frame_len(word9_reg);
        brk_tail_next = 1'b1;
      end else if (brk_tail_reg) begin
        kind_next = FK_MARK; // R05 R17
        shift_next = FRAME_ONES;
        frame_len_next = MARK_LEN;
        brk_tail_next = 1'b0;
      end else if (hold_valid_reg) begin
        kind_next = FK_DATA;
        shift_next = build_frame(word9_reg, hold_reg); // R09
        frame_len_next = frame_len(word9_reg);
        hold_valid_next = wr_data && busy;
        tx_buffer_empty_flag_next = 1'b1; // R12
      end else if (wr_data && !busy) begin
        kind_next = FK_DATA;
        shift_next = build_frame(word9_reg, {t8_reg, i_wdata}); // R14
        frame_len_next = frame_len(word9_reg);
        tx_buffer_empty_flag_next = 1'b1; // R14
      end else begin
        launch = 1'b0;
        state_next = end_evt ? TX_QUIET : state_reg;
        shift_next = end_evt ? shift_reg : shift_next;
        bit_cnt_next = end_evt ? bit_cnt_reg : bit_cnt_next;
      end
      if (launch) begin
        line_next = shift_next[0]; // R02
      end
    end else if (wr_data && !busy && !te_reg) begin
      hold_next = {t8_reg, i_wdata};
      hold_valid_next = 1'b1;
    end

    // Turning off drops the held word; turning on queues an idle frame
    if (te_fall) begin
      hold_valid_next = 1'b0; // R18
      pend_idle_next = 1'b0;
      tx_buffer_empty_flag_next = 1'b1;
    end
    if (te_rise) begin
      pend_idle_next = 1'b1; // R10 R18
    end

    pin_next = te_next || (state_next == TX_FRAME); // R10 R19
    irq_next = !i_cpu_irq_mask && ((tx_buffer_empty_flag_reg && tie_reg) || (tc_reg && tx_complete_irq_en_reg)); // R13 R15

    rdata_next = '0;
    if (i_rd) begin
      unique case (i_addr)
        ADR_STATUS: begin
          rdata_next[ST_TX_BUFFER_EMPTY_FLAG_BIT] = tx_buffer_empty_flag_reg;
          rdata_next[ST_TC_BIT] = tc_reg;
          rdata_next[ST_BUSY_BIT] = busy;
        end
        ADR_CONTROL_ONE: begin
          rdata_next[C1_T8_BIT] = t8_reg;
          rdata_next[C1_WORD9_BIT] = word9_reg;
        end
        ADR_CONTROL_TWO: begin
          rdata_next[C2_TIE_BIT] = tie_reg;
          rdata_next[C2_TX_COMPLETE_IRQ_EN_BIT] = tx_complete_irq_en_reg;
          rdata_next[C2_TE_BIT] = te_reg;
          rdata_next[C2_SBK_BIT] = sbk_reg;
        end
        ADR_BAUD: rdata_next = baud_reg;
        default: rdata_next = '0;
      endcase
    end
  end

  always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
    if (!i_rst_b) begin
      state_reg <= TX_QUIET;
      kind_reg <= FK_IDLE;
      shift_reg <= FRAME_ONES;
      bit_cnt_reg <= '0;
      frame_len_reg <= FRAME_LEN8;
      hold_reg <= '0;
      hold_valid_reg <= 1'b0;
      tx_buffer_empty_flag_reg <= TX_BUFFER_EMPTY_FLAG_RST;
      tc_reg <= TC_RST;
      seen_reg <= 1'b0;
      pend_idle_reg <= 1'b0;
      brk_tail_reg <= 1'b0;
      line_reg <= 1'b1;
      pin_reg <= 1'b0;
      irq_reg <= 1'b0;
      rdata_reg <= '0;
    end else begin
      state_reg <= state_next;
      kind_reg <= kind_next;
      shift_reg <= shift_next;
      bit_cnt_reg <= bit_cnt_next;
      frame_len_reg <= frame_len_next;
      hold_reg <= hold_next;
      hold_valid_reg <= hold_valid_next;
      tx_buffer_empty_flag_reg <= tx_buffer_empty_flag_next;
      tc_reg <= tc_next;
      seen_reg <= seen_next;
      pend_idle_reg <= pend_idle_next;
      brk_tail_reg <= brk_tail_next;
      line_reg <= line_next;
      pin_reg <= pin_next;
      irq_reg <= irq_next;
      rdata_reg <= rdata_next;
    end
  end

  assign o_rdata = rdata_reg;
  assign o_tx_data = line_reg;
  assign o_tx_pin_serial = pin_reg;
  assign o_irq = irq_reg;

  default clocking cb @(posedge i_clk_sys); endclocking
  default disable iff (!i_rst_b);

  property p_start_low;
    launch && kind_next == FK_DATA |=> !o_tx_data && bit_cnt_reg == 4'h0;
  endproperty
  a_start_low: assert property (p_start_low) else $error("start bit not low"); // R02

  property p_stop_high;
    busy && kind_reg == FK_DATA && bit_cnt_reg == frame_len_reg - 4'h1 |-> o_tx_data;
  endproperty
  a_stop_high: assert property (p_stop_high) else $error("stop bit not high"); // R03

  property p_idle_ones;
    busy && kind_reg == FK_IDLE |-> o_tx_data;
  endproperty
  a_idle_ones: assert property (p_idle_ones) else $error("idle frame not all ones"); // R04

  property p_break_zeros;
    busy && kind_reg == FK_BREAK |-> !o_tx_data;
  endproperty
  a_break_zeros: assert property (p_break_zeros) else $error("break frame not all zeros"); // R05

  property p_word_len;
    launch && kind_next == FK_DATA |=> frame_len_reg == ($past(word9_reg) ? FRAME_LEN9 : FRAME_LEN8);
  endproperty
  a_word_len: assert property (p_word_len) else $error("frame length wrong"); // R01

  property p_direct_load;
    wr_data && !busy && te_reg && !pend_idle_reg && !sbk_reg && !brk_tail_reg && !hold_valid_reg
      |=> busy && tx_buffer_empty_flag_reg && kind_reg == FK_DATA;
  endproperty
  a_direct_load: assert property (p_direct_load) else $error("idle write did not start"); // R14

  property p_tx_buffer_empty_flag_clear;
    $fell(tx_buffer_empty_flag_reg) |-> $past(wr_data) && $past(seen_reg);
  endproperty
  a_tx_buffer_empty_flag_clear: assert property (p_tx_buffer_empty_flag_clear) else $error("empty flag cleared out of order"); // R11

  property p_tc_set;
    end_evt && (kind_reg == FK_DATA || kind_reg == FK_BREAK) |=> tc_reg;
  endproperty
  a_tc_set: assert property (p_tc_set) else $error("complete flag not set"); // R15

  property p_irq;
    tx_buffer_empty_flag_reg && tie_reg && !i_cpu_irq_mask |=> o_irq;
  endproperty
  a_irq: assert property (p_irq) else $error("empty interrupt missing"); // R13

  property p_quiet_high;
    te_reg && !busy |-> o_tx_data && o_tx_pin_serial;
  endproperty
  a_quiet_high: assert property (p_quiet_high) else $error("quiet line not high"); // R19

  c_data_frame: cover property (end_evt && kind_reg == FK_DATA);
  c_break_tail: cover property (launch && kind_next == FK_MARK);
  c_held_word: cover property (launch && kind_next == FK_DATA && hold_valid_reg);
endmodule // ast_transmitter
`default_nettype wire

// ==== verification/ast_rx_model.sv ====
`timescale 1ns/1ns
`default_nettype none
module ast_rx_model #(
  parameter int BIT_CLKS = 32
) (
  input wire logic i_clk_sys,
  input wire logic i_line,
  input wire logic i_en,
  input wire logic [3:0] i_nbits,
  output logic [8:0] o_word,
  output logic o_stop,
  output int o_count
);
  logic [8:0] w;
  // Samples mid bit, so a start edge a cycle late or early still decodes
  initial begin
    o_word = '0;
    o_stop = 1'b0;
    o_count = 0;
    forever begin
      @(negedge i_line);
      repeat (BIT_CLKS / 2) @(posedge i_clk_sys);
      if (i_en && i_line === 1'b0) begin
        w = '0;
        for (int i = 0; i < int'(i_nbits); i++) begin
          repeat (BIT_CLKS) @(posedge i_clk_sys);
          w[i] = i_line;
        end
        repeat (BIT_CLKS) @(posedge i_clk_sys);
        o_stop = i_line;
        o_word = w;
        o_count++;
      end
    end
  end
endmodule // ast_rx_model
`default_nettype wire

// ==== verification/ast_transmitter_tb.sv ====
`timescale 1ns/1ns
`default_nettype none
module ast_transmitter_tb
  import ast_pkg::*;
;
  logic i_clk_sys = 1'b0;
  logic i_rst_b = 1'b0;
  logic [ADDR_W-1:0] i_addr = '0;
  logic [DATA_W-1:0] i_wdata = '0;
  logic i_wr = 1'b0;
  logic i_rd = 1'b0;
  logic i_cpu_irq_mask = 1'b1;
  logic [DATA_W-1:0] o_rdata;
  logic o_tx_data;
  logic o_tx_pin_serial;
  logic o_irq;
  logic [3:0] nbits = 4'h8;
  logic [8:0] rx_word;
  logic rx_stop;
  int rx_count;
  int n_errors = 0;
  int num_checks = 0;
  logic [DATA_W-1:0] rv;

  always #4 i_clk_sys = ~i_clk_sys;

  ast_transmitter u_ast_transmitter (.i_clk_sys(i_clk_sys), .i_rst_b(i_rst_b), .i_addr(i_addr),
    .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .i_cpu_irq_mask(i_cpu_irq_mask), .o_rdata(o_rdata),
    .o_tx_data(o_tx_data), .o_tx_pin_serial(o_tx_pin_serial), .o_irq(o_irq));
  // Baud register is set to 1, so one bit lasts 32 clocks
  ast_rx_model #(.BIT_CLKS(32)) u_ast_rx_model (.i_clk_sys(i_clk_sys), .i_line(o_tx_data),
    .i_en(o_tx_pin_serial), .i_nbits(nbits), .o_word(rx_word), .o_stop(rx_stop), .o_count(rx_count));

  task chk(input logic [15:0] seen, input logic [15:0] exp);
    num_checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
    @(posedge i_clk_sys);
    i_addr <= a;
    i_wdata <= d;
    i_wr <= 1'b1;
    @(posedge i_clk_sys);
    i_wr <= 1'b0;
  endtask

  task rd(input logic [ADDR_W-1:0] a);
    @(posedge i_clk_sys);
    i_addr <= a;
    i_rd <= 1'b1;
    @(posedge i_clk_sys);
    i_rd <= 1'b0;
    @(negedge i_clk_sys);
    rv = o_rdata;
  endtask

  task rchk(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] e);
    rd(a);
    chk(rv, e);
  endtask

  task wait_rx(input int n);
    int k;
    k = 0;
    while (rx_count < n && k < 20000) begin
      @(posedge i_clk_sys);
      k++;
    end
    chk(rx_count >= n, 1'b1);
  endtask

  task t_reset();
    @(negedge i_clk_sys);
    chk(o_tx_pin_serial, 1'b0);
    chk(o_tx_data, 1'b1);
    rchk(ADR_STATUS, 8'h03);
    rchk(ADR_BAUD, BAUD_RST);
    rchk(ADR_CONTROL_TWO, 8'h00);
    rchk(ADR_DATA, 8'h00);
    rchk(3'h7, 8'h00);
  endtask

  task t_enable();
    int k;
    wr(ADR_BAUD, 8'h01);
    wr(ADR_CONTROL_TWO, 8'h04);
    @(negedge i_clk_sys);
    chk(o_tx_pin_serial, 1'b1);
    // Written during the idle frame, so it must wait in the holding buffer
    wr(ADR_DATA, 8'ha5);
    k = 0;
    while (o_tx_data === 1'b1 && k < 400) begin
      @(negedge i_clk_sys);
      k++;
    end
    chk(k > 300 && k < 340, 1'b1);
    wait_rx(1);
    chk(rx_word, 9'h0a5);
    chk(rx_stop, 1'b1);
  endtask

  task t_direct();
    repeat (40) @(posedge i_clk_sys);
    rchk(ADR_STATUS, 8'h03);
    wr(ADR_DATA, 8'h3c);
    @(negedge i_clk_sys);
    chk(o_tx_data, 1'b0);
    rchk(ADR_STATUS, 8'h05);
    wr(ADR_DATA, 8'hc3);
    rchk(ADR_STATUS, 8'h04);
    wait_rx(2);
    chk(rx_word, 9'h03c);
    repeat (24) @(posedge i_clk_sys);
    rd(ADR_STATUS);
    chk(rv[ST_TX_BUFFER_EMPTY_FLAG_BIT], 1'b1);
    chk(rv[ST_BUSY_BIT], 1'b1);
    wait_rx(3);
    chk(rx_word, 9'h0c3);
    repeat (40) @(posedge i_clk_sys);
    rchk(ADR_STATUS, 8'h03);
  endtask

  task t_nine();
    wr(ADR_CONTROL_ONE, 8'h03);
    nbits <= 4'h9;
    rchk(ADR_CONTROL_ONE, 8'h03);
    rd(ADR_STATUS);
    wr(ADR_DATA, 8'h55);
    wait_rx(4);
    chk(rx_word, 9'h155);
    chk(rx_stop, 1'b1);
    repeat (40) @(posedge i_clk_sys);
    wr(ADR_CONTROL_ONE, 8'h00);
    nbits <= 4'h8;
  endtask

  task t_break();
    int k;
    wr(ADR_CONTROL_TWO, 8'h0c);
    wait_rx(5);
    chk(rx_word, 9'h000);
    chk(rx_stop, 1'b0);
    repeat (400) @(negedge i_clk_sys);
    chk(o_tx_data, 1'b0);
    wr(ADR_CONTROL_TWO, 8'h04);
    k = 0;
    while (o_tx_data === 1'b0 && k < 800) begin
      @(negedge i_clk_sys);
      k++;
    end
    chk(k < 800, 1'b1);
    rd(ADR_STATUS);
    chk(rv[ST_TC_BIT], 1'b1);
    wr(ADR_DATA, 8'h81);
    wait_rx(6);
    chk(rx_word, 9'h081);
    repeat (40) @(posedge i_clk_sys);
  endtask

  task t_irq();
    wr(ADR_CONTROL_TWO, 8'h05);
    repeat (3) @(negedge i_clk_sys);
    chk(o_irq, 1'b0);
    @(posedge i_clk_sys);
    i_cpu_irq_mask <= 1'b0;
    repeat (3) @(negedge i_clk_sys);
    chk(o_irq, 1'b1);
    wr(ADR_CONTROL_TWO, 8'h06);
    repeat (3) @(negedge i_clk_sys);
    chk(o_irq, 1'b1);
    rd(ADR_STATUS);
    wr(ADR_DATA, 8'h11);
    repeat (3) @(negedge i_clk_sys);
    chk(o_irq, 1'b0);
    wait_rx(7);
    repeat (40) @(negedge i_clk_sys);
    chk(o_irq, 1'b1);
    @(posedge i_clk_sys);
    i_cpu_irq_mask <= 1'b1;
    repeat (3) @(negedge i_clk_sys);
    chk(o_irq, 1'b0);
    wr(ADR_CONTROL_TWO, 8'h04);
  endtask

  task t_toggle();
    rd(ADR_STATUS);
    wr(ADR_DATA, 8'h5a);
    wr(ADR_DATA, 8'h6b);
    // Off then on mid frame: the held byte is thrown away
    wr(ADR_CONTROL_TWO, 8'h00);
    wr(ADR_CONTROL_TWO, 8'h04);
    repeat (1500) @(negedge i_clk_sys);
    chk(rx_count, 16'h0008);
    chk(rx_word, 9'h05a);
    chk(o_tx_data, 1'b1);
    wr(ADR_CONTROL_TWO, 8'h00);
    repeat (3) @(negedge i_clk_sys);
    chk(o_tx_pin_serial, 1'b0);
  endtask

  task summarize();
    $display("checks %0d errors %0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  initial begin
    repeat (60000) @(posedge i_clk_sys);
    n_errors++;
    summarize();
  end

  initial begin
    repeat (16) @(posedge i_clk_sys);
    i_rst_b <= 1'b1;
    t_reset();
    t_enable();
    t_direct();
    t_nine();
    t_break();
    t_irq();
    t_toggle();
    summarize();
  end
endmodule // ast_transmitter_tb
`default_nettype wire
